/* verilog/tcir_regs.sv */
// Register slice of one time-to-digital converter channel.
// Assumes the measurement engine pulses start, done and reports counters.
// What this block does
// - Calibration select picks 2/10/20/40 periods
// - Averaging count is two to the code
// - Stop codes 0-4 give 1-5, rest 1
// - Three interrupt bits clear on written one
// - Done and begun flags clear on one
// - Done flag set when measurement completes
// - Begun flag set on received start event
// - Reference counter limit sets flag, aborts
// - Coarse counter limit sets flag, aborts
// - Result bit set on finished measurement
// - Enable bits gate interrupts, reset 07h
// - Disabled interrupt still held in status
// - Coarse limit bytes at 04h/05h, FFh
// - Reference limit high byte 06h, FFh
// - Reference limit low byte 07h, FFh
// - Launch write clears status, starts measurement
module tcir_regs
	import tcir_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             resetn_i,
	// Serial port pins
	input  wire logic             sclk_i,
	input  wire logic             channel_select_n_i,
	input  wire logic             sdi_i,
	output logic                  sdo_o,
	output logic                  sdo_oe_o,
	// Interrupt pin
	output logic                  irq_out_n_o,
	// Measurement engine events
	input  wire logic             meas_busy_i,
	input  wire logic             meas_start_seen_i,
	input  wire logic             meas_done_i,
	input  wire logic [CNT_W-1:0] coarse_count_i,
	input  wire logic [CNT_W-1:0] refclk_count_i,
	// Measurement engine controls
	output logic                  launch_o,
	output logic                  abort_o,
	output logic [7:0]            setup_one_o,
	output logic [7:0]            cal_periods_o,
	output logic [7:0]            averaging_count_select_o,
	output logic [2:0]            stop_count_o,
	output logic [CNT_W-1:0]      coarse_limit_o,
	output logic [CNT_W-1:0]      refclk_limit_o
);

	// Calibration run length from its select code
	function automatic logic [7:0] cal_len(input logic [1:0] code);
		logic [7:0] len;
		len = CAL_LEN_0;
		case (code)
			2'h0: len = CAL_LEN_0;
			2'h1: len = CAL_LEN_1;
			2'h2: len = CAL_LEN_2;
			2'h3: len = CAL_LEN_3;
			default: len = CAL_LEN_0;
		endcase
		return len;
	endfunction

	// Averaging cycles: one shifted by the code
	function automatic logic [7:0] avg_len(input logic [2:0] code);
		return 8'(8'h01 << code);
	endfunction

	// Stop events: codes above the top valid one fall back to one
	function automatic logic [2:0] stop_len(input logic [2:0] code);
		logic [2:0] n;
		if (code <= STOP_CODE_MAX) begin
			n = 3'(code + 3'h1);
		end else begin
			n = 3'h1;
		end
		return n;
	endfunction

	// Flag update where a new event outweighs a clear in the same cycle
	function automatic logic [FLAGS_USED-1:0] flag_next(
		input logic [FLAGS_USED-1:0] cur,
		input logic [FLAGS_USED-1:0] set,
		input logic [FLAGS_USED-1:0] clr
	);
		return (cur & ~clr) | set;
	endfunction

	// Write strobe aimed at one register offset
	function automatic logic wr_to(input tcir_req_t r, input logic [5:0] ofs);
		return r.wr && (r.addr == ofs);
	endfunction

	// Register state
	logic [7:0]              setup_one_ff;
	logic [7:0]              setup_two_ff;
	logic [FLAGS_USED-1:0]   flags_ff;
	logic [ENABLES_USED-1:0] enables_ff;
	logic [7:0]              coarse_hi_ff;
	logic [7:0]              coarse_lo_ff;
	logic [7:0]              refclk_hi_ff;
	logic [7:0]              refclk_lo_ff;
	logic                    coarse_hit_ff;
	logic                    refclk_hit_ff;
	logic                    launch_ff;
	logic                    abort_ff;
	logic                    irq_n_ff;

	// Combinational helpers
	tcir_req_t               req;
	logic [5:0]              rd_addr;
	logic [7:0]              rd_data;
	logic                    wr_setup_one;
	logic                    wr_flags;
	logic                    launch_req;
	logic                    coarse_hit;
	logic                    refclk_hit;
	logic                    coarse_ovf;
	logic                    refclk_ovf;
	logic [FLAGS_USED-1:0]   flag_set;
	logic [FLAGS_USED-1:0]   flag_clr;
	logic [FLAGS_USED-1:0]   nxt_flags;
	logic [CNT_W-1:0]        coarse_limit;
	logic [CNT_W-1:0]        refclk_limit;

	tcir_serial_port u_port (
		.mclk_i             (mclk_i),
		.resetn_i           (resetn_i),
		.sclk_i             (sclk_i),
		.channel_select_n_i (channel_select_n_i),
		.sdi_i              (sdi_i),
		.sdo_o              (sdo_o),
		.sdo_oe_o           (sdo_oe_o),
		.req_o              (req),
		.rd_addr_o          (rd_addr),
		.rd_data_i          (rd_data)
	);

	assign wr_setup_one = wr_to(req, OFS_SETUP_ONE);
	assign wr_flags     = wr_to(req, OFS_IRQ_FLAGS);
	assign launch_req   = wr_setup_one && req.wdata[LAUNCH_BIT];

	assign coarse_limit = CNT_W'({coarse_hi_ff, coarse_lo_ff});
	assign refclk_limit = CNT_W'({refclk_hi_ff, refclk_lo_ff});

	assign coarse_hit = meas_busy_i && (coarse_count_i >= coarse_limit);
	assign refclk_hit = meas_busy_i && (refclk_count_i >= refclk_limit);
	// Only the first cycle of a hit counts, so one abort per overrun
	assign coarse_ovf = coarse_hit && !coarse_hit_ff;
	assign refclk_ovf = refclk_hit && !refclk_hit_ff;

	always_comb begin
		flag_set = '0;
		flag_set[FLAG_RESULT]     = meas_done_i;
		flag_set[FLAG_RING_OVF]   = coarse_ovf;
		flag_set[FLAG_REFCLK_OVF] = refclk_ovf;
		flag_set[FLAG_BEGUN]      = meas_start_seen_i;
		flag_set[FLAG_DONE]       = meas_done_i;
	end

	always_comb begin
		flag_clr = '0;
		if (wr_flags) begin
			flag_clr = req.wdata[FLAGS_USED-1:0];
		end
		if (launch_req) begin
			flag_clr = '1;
		end
	end

	// flags are kept whatever the enables say
	assign nxt_flags = flag_next(flags_ff, flag_set, flag_clr);

	// Read multiplexer; reserved bits and unmapped addresses read zero
	always_comb begin
		rd_data = 8'h00;
		case (rd_addr)
			OFS_SETUP_ONE:   rd_data = setup_one_ff;
			OFS_SETUP_TWO:   rd_data = setup_two_ff;
			OFS_IRQ_FLAGS:   rd_data = 8'(flags_ff);
			OFS_IRQ_ENABLES: rd_data = 8'(enables_ff);
			OFS_COARSE_HI:   rd_data = coarse_hi_ff;
			OFS_COARSE_LO:   rd_data = coarse_lo_ff;
			OFS_REFCLK_HI:   rd_data = refclk_hi_ff;
			OFS_REFCLK_LO:   rd_data = refclk_lo_ff;
			default:         rd_data = 8'h00;
		endcase
	end

	// First setup register; launch bit stays set until the run ends
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			setup_one_ff <= RST_SETUP_ONE;
		end else if (wr_setup_one) begin
			setup_one_ff <= req.wdata;
		end else if (meas_done_i || coarse_ovf || refclk_ovf) begin
			setup_one_ff[LAUNCH_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			setup_two_ff <= RST_SETUP_TWO;
		end else if (wr_to(req, OFS_SETUP_TWO)) begin
			setup_two_ff <= req.wdata;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flags_ff <= FLAGS_USED'(RST_IRQ_FLAGS);
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			enables_ff <= ENABLES_USED'(RST_IRQ_ENABLES);
		end else if (wr_to(req, OFS_IRQ_ENABLES)) begin
			enables_ff <= req.wdata[ENABLES_USED-1:0];
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			coarse_hi_ff <= RST_LIMIT_BYTE;
			coarse_lo_ff <= RST_LIMIT_BYTE;
		end else begin
			if (wr_to(req, OFS_COARSE_HI)) begin
				coarse_hi_ff <= req.wdata;
			end
			if (wr_to(req, OFS_COARSE_LO)) begin
				coarse_lo_ff <= req.wdata;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			refclk_hi_ff <= RST_LIMIT_BYTE;
			refclk_lo_ff <= RST_LIMIT_BYTE;
		end else begin
			if (wr_to(req, OFS_REFCLK_HI)) begin
				refclk_hi_ff <= req.wdata;
			end
			if (wr_to(req, OFS_REFCLK_LO)) begin
				refclk_lo_ff <= req.wdata;
			end
		end
	end

	// Coarse hit history for edge detection
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			coarse_hit_ff <= 1'b0;
		end else begin
			coarse_hit_ff <= coarse_hit;
		end
	end

	// Reference hit history, kept apart so either counter may abort
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			refclk_hit_ff <= 1'b0;
		end else begin
			refclk_hit_ff <= refclk_hit;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			launch_ff <= 1'b0;
		end else begin
			launch_ff <= launch_req;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			abort_ff <= 1'b0;
		end else begin
			abort_ff <= coarse_ovf || refclk_ovf;
		end
	end

	// interrupt pin from enabled flags, one cycle behind them
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_n_ff <= 1'b1;
		end else begin
			irq_n_ff <= ~|(flags_ff[ENABLES_USED-1:0] & enables_ff);
		end
	end

	// Decoded settings for the engine, registered as data outputs
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cal_periods_o <= cal_len(RST_SETUP_TWO[CAL_SEL_LSB +: 2]);
			averaging_count_select_o  <= avg_len(RST_SETUP_TWO[AVG_SEL_LSB +: 3]);
			stop_count_o  <= stop_len(RST_SETUP_TWO[STOP_SEL_LSB +: 3]);
		end else begin
			cal_periods_o <= cal_len(setup_two_ff[CAL_SEL_LSB +: 2]);
			averaging_count_select_o  <= avg_len(setup_two_ff[AVG_SEL_LSB +: 3]);
			stop_count_o  <= stop_len(setup_two_ff[STOP_SEL_LSB +: 3]);
		end
	end

	assign launch_o       = launch_ff;
	assign abort_o        = abort_ff;
	assign irq_out_n_o    = irq_n_ff;
	assign setup_one_o    = setup_one_ff;
	assign coarse_limit_o = coarse_limit;
	assign refclk_limit_o = refclk_limit;

endmodule // tcir_regs

/* verilog/tcir_pkg.sv */
// Constants and carrier types for the converter channel register slice.
// Assumes 8-bit registers reached over a serial port with a 6-bit address.
package tcir_pkg;

	// Register offsets
	localparam logic [5:0] OFS_SETUP_ONE   = 6'h00;
	localparam logic [5:0] OFS_SETUP_TWO   = 6'h01;
	localparam logic [5:0] OFS_IRQ_FLAGS   = 6'h02;
	localparam logic [5:0] OFS_IRQ_ENABLES = 6'h03;
	localparam logic [5:0] OFS_COARSE_HI   = 6'h04;
	localparam logic [5:0] OFS_COARSE_LO   = 6'h05;
	localparam logic [5:0] OFS_REFCLK_HI   = 6'h06;
	localparam logic [5:0] OFS_REFCLK_LO   = 6'h07;

	// Reset values
	localparam logic [7:0] RST_SETUP_ONE   = 8'h00;
	localparam logic [7:0] RST_SETUP_TWO   = 8'h40;
	localparam logic [7:0] RST_IRQ_FLAGS   = 8'h00;
	localparam logic [7:0] RST_IRQ_ENABLES = 8'h07;
	localparam logic [7:0] RST_LIMIT_BYTE  = 8'hFF;

	// Field positions
	localparam int LAUNCH_BIT     = 0;
	localparam int CAL_SEL_LSB    = 6;
	localparam int AVG_SEL_LSB    = 3;
	localparam int STOP_SEL_LSB   = 0;
	localparam int FLAG_RESULT    = 0;
	localparam int FLAG_RING_OVF  = 1;
	localparam int FLAG_REFCLK_OVF = 2;
	localparam int FLAG_BEGUN     = 3;
	localparam int FLAG_DONE      = 4;
	localparam int FLAGS_USED     = 5;
	localparam int ENABLES_USED   = 3;

	// Command byte layout
	localparam int CMD_INCR_BIT   = 7;
	localparam int CMD_WRITE_BIT  = 6;

	// Calibration lengths in reference clock periods
	localparam logic [7:0] CAL_LEN_0 = 8'h02;
	localparam logic [7:0] CAL_LEN_1 = 8'h0A;
	localparam logic [7:0] CAL_LEN_2 = 8'h14;
	localparam logic [7:0] CAL_LEN_3 = 8'h28;
	localparam logic [2:0] STOP_CODE_MAX = 3'h4;

	// One register access from the serial port
	typedef struct packed {
		logic       wr;
		logic [5:0] addr;
		logic [7:0] wdata;
	} tcir_req_t;

endpackage : tcir_pkg

/* verilog/tcir_serial_port.sv */
// Serial register port: command byte then data bytes, mode 0.
// Assumes the pins are already synchronous to mclk_i and sclk is slower.
module tcir_serial_port
	import tcir_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       resetn_i,
	// Pins
	input  wire logic       sclk_i,
	input  wire logic       channel_select_n_i,
	input  wire logic       sdi_i,
	output logic            sdo_o,
	output logic            sdo_oe_o,
	// Register side
	output tcir_req_t       req_o,
	output logic [5:0]      rd_addr_o,
	input  wire logic [7:0] rd_data_i
);
	logic       sclk_prev_ff;
	logic [2:0] bit_cnt_ff;
	logic       data_phase_ff;
	logic       write_ff;
	logic       incr_ff;
	logic [5:0] addr_ff;
	logic [7:0] shin_ff;
	logic [7:0] shout_ff;
	logic       rise;
	logic       fall;
	logic       byte_end;
	logic [7:0] nxt_byte;
	logic [5:0] nxt_addr;

	assign rise     = sclk_i & ~sclk_prev_ff & ~channel_select_n_i;
	assign fall     = ~sclk_i & sclk_prev_ff & ~channel_select_n_i;
	assign byte_end = rise && (bit_cnt_ff == 3'h7);
	assign nxt_byte = {shin_ff[6:0], sdi_i};
	assign nxt_addr = incr_ff ? 6'(addr_ff + 6'h01) : addr_ff;
	// Address whose data is loaded at the end of the current byte
	assign rd_addr_o = data_phase_ff ? nxt_addr : nxt_byte[5:0];
	assign sdo_o     = shout_ff[7];
	assign sdo_oe_o  = ~channel_select_n_i;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sclk_prev_ff <= 1'b0;
		end else begin
			sclk_prev_ff <= sclk_i;
		end
	end

	// Framing: select high restarts at the command byte
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bit_cnt_ff    <= 3'h0;
			data_phase_ff <= 1'b0;
			write_ff      <= 1'b0;
			incr_ff       <= 1'b0;
			addr_ff       <= 6'h00;
			shin_ff       <= 8'h00;
		end else if (channel_select_n_i) begin
			bit_cnt_ff    <= 3'h0;
			data_phase_ff <= 1'b0;
		end else if (rise) begin
			bit_cnt_ff <= 3'(bit_cnt_ff + 3'h1);
			shin_ff    <= nxt_byte;
			if (byte_end && !data_phase_ff) begin
				data_phase_ff <= 1'b1;
				incr_ff       <= nxt_byte[CMD_INCR_BIT];
				write_ff      <= nxt_byte[CMD_WRITE_BIT];
				addr_ff       <= nxt_byte[5:0];
			end else if (byte_end) begin
				addr_ff <= nxt_addr;
			end
		end
	end

	// Write strobe after each full data byte
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			req_o <= '0;
		end else begin
			req_o.wr    <= byte_end && data_phase_ff && write_ff;
			req_o.addr  <= addr_ff;
			req_o.wdata <= nxt_byte;
		end
	end

	// Read data loads at byte end; first falling edge after it is skipped
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			shout_ff <= 8'h00;
		end else if (byte_end && (data_phase_ff ? !write_ff : !nxt_byte[CMD_WRITE_BIT])) begin
			shout_ff <= rd_data_i;
		end else if (fall && (bit_cnt_ff != 3'h0)) begin
			shout_ff <= {shout_ff[6:0], 1'b0};
		end
	end

endmodule // tcir_serial_port

/* tb/tcir_regs_checker.sv */
// Checker for the converter channel register slice, bound to its top module.
// Assumes one clock domain and the asynchronous active-low reset.
module tcir_regs_checker
	import tcir_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic             mclk_i,
	input wire logic             resetn_i,
	// Pins
	input wire logic             channel_select_n_i,
	input wire logic             irq_out_n_o,
	// Engine side
	input wire logic             meas_busy_i,
	input wire logic             meas_done_i,
	input wire logic [CNT_W-1:0] coarse_count_i,
	input wire logic [CNT_W-1:0] refclk_count_i,
	input wire logic             launch_o,
	input wire logic             abort_o,
	input wire logic [7:0]       cal_periods_o,
	input wire logic [7:0]       averaging_count_select_o,
	input wire logic [2:0]       stop_count_o,
	input wire logic [CNT_W-1:0] coarse_limit_o,
	input wire logic [CNT_W-1:0] refclk_limit_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	logic hit_c;
	logic hit_r;
	logic hit_c_ff;
	logic hit_r_ff;
	assign hit_c = meas_busy_i && (coarse_count_i >= coarse_limit_o);
	assign hit_r = meas_busy_i && (refclk_count_i >= refclk_limit_o);
	// One history per counter: a fresh hit on either aborts even during the other's
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hit_c_ff <= 1'h0;
			hit_r_ff <= 1'h0;
		end else begin
			hit_c_ff <= hit_c;
			hit_r_ff <= hit_r;
		end
	end

	cal_length_a: assert property (cal_periods_o inside {8'h02, 8'h0A, 8'h14, 8'h28})
		else $error("calibration length off the table");
	avg_power_a: assert property ($onehot(averaging_count_select_o))
		else $error("averaging count not a power of two");
	stop_range_a: assert property (stop_count_o inside {[3'h1:3'h5]})
		else $error("stop count out of range");
	coarse_abort_a: assert property (hit_c && !hit_c_ff |=> abort_o)
		else $error("coarse limit hit without abort");
	refclk_abort_a: assert property (hit_r && !hit_r_ff |=> abort_o)
		else $error("reference limit hit without abort");
	abort_cause_a: assert property (abort_o |->
		$past(hit_c && !hit_c_ff) || $past(hit_r && !hit_r_ff))
		else $error("abort without a fresh limit hit");
	launch_pulse_a: assert property (launch_o |=> !launch_o)
		else $error("launch longer than one cycle");
	limit_reset_a: assert property ($rose(resetn_i) |->
		coarse_limit_o == '1 && refclk_limit_o == '1)
		else $error("limits not all ones after reset");
	irq_cause_a: assert property ($fell(irq_out_n_o) |->
		$past(meas_done_i, 2) || $past(abort_o) || !$past(channel_select_n_i))
		else $error("interrupt pin fell without a cause");

	launch_seen_c: cover property (launch_o);
	abort_seen_c: cover property (abort_o);
	irq_seen_c: cover property ($fell(irq_out_n_o));
endmodule // tcir_regs_checker

bind tcir_regs tcir_regs_checker #(.CNT_W(CNT_W)) chk_u (
	.mclk_i, .resetn_i, .channel_select_n_i, .irq_out_n_o, .meas_busy_i, .meas_done_i,
	.coarse_count_i, .refclk_count_i, .launch_o, .abort_o, .cal_periods_o,
	.averaging_count_select_o, .stop_count_o, .coarse_limit_o, .refclk_limit_o
);

/* tb/tcir_host_model.sv */
// Host model: mode 0 frames of one command byte and one or two data bytes.
// Assumes the device samples the pins with mclk; each sclk level lasts 4 mclk.
module tcir_host_model (
	// Clock
	input  wire logic mclk_i,
	// Pins
	output logic      sclk_o,
	output logic      channel_select_n_o,
	output logic      sdi_o,
	input  wire logic sdo_i
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		sclk_o = 1'h0;
		channel_select_n_o = 1'h1;
		sdi_o = 1'h0;
	end

	// Four cycles a level keeps each edge well above the sampling limit
	task automatic half();
		repeat (4) @(negedge mclk_i);
	endtask

	// Frame of nbits (16 or 24); the last 16 bits seen on sdo are returned
	task automatic frame(input logic [23:0] sh, input int nbits, output logic [15:0] rd);
		rd = '0;
		channel_select_n_o = 1'h0;
		for (int i = nbits - 1; i >= 0; i--) begin
			sdi_o = sh[i];
			half();
			sclk_o = 1'h1;
			if (i < 16) begin
				rd[i] = sdo_i;
			end
			half();
			sclk_o = 1'h0;
		end
		half();
		channel_select_n_o = 1'h1;
		// Released data line must not keep its last value
		sdi_o = ~sdi_o;
		half();
	endtask

	task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
		logic [15:0] r;
		frame({8'h00, cmd, wd}, 16, r);
		rd = r[7:0];
	endtask
endmodule // tcir_host_model

/* tb/tb.sv */
// Testbench for the register slice: host frames plus engine event stimulus.
// Assumes the host model's frames and inputs changed at the falling edge.
module tb
	import tcir_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk, resetn, sclk, select_n, sdi, sdo, sdo_oe, irq_n;
	logic        busy, start_seen, done, launch, abort, got_launch, got_abort, clr_seen;
	logic [15:0] ccnt, rcnt, climit, rlimit, rw;
	logic [7:0]  s1, calp, avg, rv;
	logic [2:0]  stopc;
	int          errors, checks;
	logic [7:0]  rst_tab [9] = '{8'h00, 8'h40, 8'h00, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
	logic [7:0]  cal_tab [4] = '{8'h02, 8'h0A, 8'h14, 8'h28};

	tcir_regs #(.CNT_W(16)) dut_u (
		.mclk_i(mclk), .resetn_i(resetn), .sclk_i(sclk), .channel_select_n_i(select_n),
		.sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .irq_out_n_o(irq_n),
		.meas_busy_i(busy), .meas_start_seen_i(start_seen), .meas_done_i(done),
		.coarse_count_i(ccnt), .refclk_count_i(rcnt), .launch_o(launch), .abort_o(abort),
		.setup_one_o(s1), .cal_periods_o(calp), .averaging_count_select_o(avg), .stop_count_o(stopc),
		.coarse_limit_o(climit), .refclk_limit_o(rlimit)
	);
	tcir_host_model host_u (
		.mclk_i(mclk), .sclk_o(sclk), .channel_select_n_o(select_n), .sdi_o(sdi), .sdo_i(sdo)
	);

	initial begin
		mclk = 1'h0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (!resetn || clr_seen) begin
			got_launch <= 1'h0;
			got_abort  <= 1'h0;
		end else begin
			if (launch) got_launch <= 1'h1;
			if (abort) got_abort <= 1'h1;
		end
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		host_u.xfer({2'h1, a}, d, rv);
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
		host_u.xfer({2'h0, a}, 8'h00, rv);
		chk($sformatf("register %h", a), {8'h00, exp}, {8'h00, rv});
	endtask
	task automatic ev(input logic st, input logic dn);
		start_seen = st;
		done = dn;
		@(negedge mclk);
		start_seen = 1'h0;
		done = 1'h0;
		repeat (4) @(negedge mclk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		#200000;
		errors++;
		$display("[FAIL] watchdog expected finish seen timeout");
		report_and_stop();
	end

	initial begin
		{errors, checks} = '0;
		{resetn, busy, start_seen, done, clr_seen} = '0;
		{ccnt, rcnt} = '0;
		repeat (2) @(negedge mclk);
		resetn = 1'h1;
		for (int i = 0; i < 9; i++) begin
			rd_chk(6'(i), rst_tab[i]);
		end
		chk("limits", 16'hFFFF, climit & rlimit);
		chk("sdo enable idle", 16'h0, {15'h0, sdo_oe});
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			wr(OFS_SETUP_TWO, {i[1:0], i[2:0], i[2:0]});
			chk("cal", {8'h00, cal_tab[i[1:0]]}, {8'h00, calp});
			chk("avg", 16'(1 << i), {8'h00, avg});
			chk("stop", 16'(i < 5 ? i + 1 : 1), {13'h0, stopc});
		end
		$display("test setup fields done");
		wr(OFS_IRQ_ENABLES, 8'h00);
		ev(1'h1, 1'h1);
		chk("irq masked", 16'h1, {15'h0, irq_n});
		rd_chk(OFS_IRQ_FLAGS, 8'h19);
		wr(OFS_IRQ_FLAGS, 8'h00);
		rd_chk(OFS_IRQ_FLAGS, 8'h19);
		wr(OFS_IRQ_ENABLES, 8'h01);
		chk("irq on", 16'h0, {15'h0, irq_n});
		wr(OFS_IRQ_FLAGS, 8'h01);
		rd_chk(OFS_IRQ_FLAGS, 8'h18);
		chk("irq off", 16'h1, {15'h0, irq_n});
		wr(OFS_IRQ_FLAGS, 8'h18);
		rd_chk(OFS_IRQ_FLAGS, 8'h00);
		$display("test flags done");
		wr(OFS_IRQ_ENABLES, 8'h07);
		host_u.frame({2'h3, OFS_COARSE_HI, 8'h12, 8'h34}, 24, rw);
		chk("burst write", 16'h1234, climit);
		host_u.frame({2'h2, OFS_COARSE_HI, 16'h0000}, 24, rw);
		chk("burst read", 16'h1234, rw);
		wr(OFS_COARSE_HI, 8'h00);
		wr(OFS_COARSE_LO, 8'h10);
		wr(OFS_REFCLK_HI, 8'h00);
		wr(OFS_REFCLK_LO, 8'h20);
		chk("coarse limit", 16'h0010, climit);
		chk("refclk limit", 16'h0020, rlimit);
		busy = 1'h1;
		ccnt = 16'h000F;
		repeat (4) @(negedge mclk);
		chk("abort early", 16'h0, {15'h0, got_abort});
		ccnt = 16'h0010;
		repeat (4) @(negedge mclk);
		chk("coarse abort", 16'h1, {15'h0, got_abort});
		chk("irq overflow", 16'h0, {15'h0, irq_n});
		busy = 1'h0;
		ccnt = 16'h0000;
		rd_chk(OFS_IRQ_FLAGS, 8'h02);
		clr_seen = 1'h1;
		@(negedge mclk);
		clr_seen = 1'h0;
		busy = 1'h1;
		rcnt = 16'h0020;
		repeat (4) @(negedge mclk);
		chk("refclk abort", 16'h1, {15'h0, got_abort});
		busy = 1'h0;
		rcnt = 16'h0000;
		rd_chk(OFS_IRQ_FLAGS, 8'h06);
		$display("test overflow done");
		wr(OFS_SETUP_ONE, 8'h01);
		chk("launch", 16'h1, {15'h0, got_launch});
		chk("irq cleared", 16'h1, {15'h0, irq_n});
		chk("setup one", 16'h0001, {8'h00, s1});
		rd_chk(OFS_IRQ_FLAGS, 8'h00);
		ev(1'h0, 1'h1);
		rd_chk(OFS_IRQ_FLAGS, 8'h11);
		rd_chk(OFS_SETUP_ONE, 8'h00);
		$display("test launch done");
		report_and_stop();
	end
endmodule // tb
